// >>> core/aicd_defines.svh
/*
 * constants of the analog input configuration decoder: jumper bit
 * positions, range and units codes, register offsets, timing counts.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef AICD_DEFINES_SVH
`define AICD_DEFINES_SVH

// ----------------------------------------------------------------------
// jumper bank (installed = 1)
// ----------------------------------------------------------------------
`define AICD_JMP_CNT_A 0
`define AICD_JMP_CNT_B 1
`define AICD_JMP_MODE 2
`define AICD_JMP_RANGE_LSB 3
`define AICD_JMP_UNITS_LSB 6

// ----------------------------------------------------------------------
// range and units codes
// ----------------------------------------------------------------------
`define AICD_RNG_BCD10 3'h0
`define AICD_RNG_BCD5 3'h1
`define AICD_RNG_BROKEN 3'h6
`define AICD_UNI_MAGSGN 2'h0
`define AICD_UNI_TC13 2'h1
`define AICD_UNI_TC12 2'h2
`define AICD_UNI_UNS 2'h3
`define AICD_FULL_SCALE 13'h0FFF
`define AICD_BCD10_K 14'h2712
`define AICD_BCD5_K 14'h138A

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define AICD_ADDR_W 4
`define AICD_REG_CTRL 4'h0
`define AICD_REG_STATUS 4'h4
`define AICD_REG_IMAGE 4'h8
`define AICD_CTRL_RST 1'h1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define AICD_CLK_NS 5
`define AICD_FLASH_HALF_US 50000
`define AICD_FLASH_HALF_CYC (`AICD_FLASH_HALF_US * 1000 / `AICD_CLK_NS)
`define AICD_BOOT_WAIT 2'h3
`define AICD_FIFO_DEPTH 8

`endif

// >>> core/aicd_pkg.sv
/*
 * types of the analog input configuration decoder.
 * assumes aicd_defines.svh on the include path.
 */
`include "aicd_defines.svh"

package aicd_pkg;

	// decoded jumper configuration
	typedef struct packed {
		logic invalid;
		logic [1:0] chan_last;
		logic mode32;
		logic [2:0] range_code;
		logic [1:0] units;
	} aicd_cfg_t;

	// one conversion from the analog front end
	typedef struct packed {
		logic open_loop;
		logic neg;
		logic [11:0] mag;
	} aicd_raw_t;

	// one queued sample, tagged with its channel
	typedef struct packed {
		logic [1:0] chan;
		aicd_raw_t raw;
	} aicd_sample_t;

	typedef enum logic [1:0] {
		AICD_ST_BOOT = 2'h0,
		AICD_ST_RUN = 2'h1,
		AICD_ST_FAULT = 2'h3
	} aicd_state_t;

endpackage : aicd_pkg

// >>> core/aicd_decoder.sv
/*
 * analog input configuration decoder: jumper decode, conversion
 * sequencing, sample queue and controller input image.
 * assumes jumpers and the scan strobe arrive asynchronously on pins,
 * and the analog front end runs on mclk.
 */
// Decided for this implementation: the address-and-strobe port and the register offsets.
//
// Summary of operation
// RQ1 - all jumpers installed: four channels, 32 inputs, 4-20 mA, unsigned.
// RQ2 - two channel-count jumpers enable channels 1 to n, n from 1 to 4.
// RQ3 - only enabled channels are converted, shortening the update cycle.
// RQ4 - mode jumper removed selects 16 inputs, installed selects 32.
// RQ5 - image spans 16 input points or 32 input points per mode.
// RQ6 - three range jumpers form a binary code of eight settings.
// RQ7 - one range applies to all four channels; wiring picks V or I.
// RQ8 - 16-input mode: bipolar magnitude plus sign, unipolar 0 to 4095.
// RQ9 - 32-input mode codes 0 and 1 give BCD, +-9999 and +-5000.
// RQ10 - two units jumpers pick one of four formats for all channels.
// RQ11 - units jumpers ignored in 16-input mode.
// RQ12 - BCD ranges ignore units jumpers and always output BCD.
// RQ13 - invalid jumpers: run indicator off, channel 1 indicator flashes.
// RQ14 - 16 inputs: one combined sign bit; 32 inputs: four sign bits.
// RQ15 - two's complement and BCD only in 32-input mode.
// RQ16 - one channel delivered per scan, cycling enabled channels from 1.
// RQ17 - word carries 12 data bits, channel bits and optional extension.
// RQ18 - range and units codes follow table order, all ones highest.
// RQ19 - 16-input mode with range code 0 or 1 is invalid.
`timescale 1ns/1ps
`include "aicd_defines.svh"

// ----------------------------------------------------------------------
// sample queue
// ----------------------------------------------------------------------
module aicd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic mclk, // clock
	input wire logic rst_n, // async reset
	input wire logic in_valid, // write request
	output logic in_ready, // room left
	input wire logic [WIDTH-1:0] in_data, // write data
	output logic out_valid, // data present
	input wire logic out_ready, // pop
	output logic [WIDTH-1:0] out_data // head entry
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
	} aicd_fifo_st_t;

	aicd_fifo_st_t s_reg;
	aicd_fifo_st_t s_next;
	logic push;
	logic pop;

	// count is one bit wider than the pointers so full and empty differ
	assign in_ready = (s_reg.count < (AW+1)'(DEPTH));
	assign out_valid = (s_reg.count != '0);
	assign out_data = s_reg.mem[s_reg.rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wptr] = in_data;
			s_next.wptr = (s_reg.wptr == AW'(DEPTH - 1)) ? '0 :
				s_reg.wptr + 1'b1;
		end
		if (pop) begin
			s_next.rptr = (s_reg.rptr == AW'(DEPTH - 1)) ? '0 :
				s_reg.rptr + 1'b1;
		end
		case ({push, pop})
			2'b10: s_next.count = s_reg.count + 1'b1;
			2'b01: s_next.count = s_reg.count - 1'b1;
			default: s_next.count = s_reg.count;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule : aicd_fifo

// ----------------------------------------------------------------------
// decoder top
// ----------------------------------------------------------------------
module aicd_decoder #(
	parameter int FLASH_HALF_CYC = `AICD_FLASH_HALF_CYC
) (
	input wire logic mclk, // 200 MHz clock
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] jumper_pins, // jumper bank, 1 = installed
	input wire logic scan_pin, // controller scan strobe
	output logic conv_req, // convert conv_chan
	output logic [1:0] conv_chan, // channel to convert
	input wire logic conv_valid, // conversion done
	output logic conv_ready, // conversion taken
	input wire aicd_pkg::aicd_raw_t conv_data, // conversion result
	output logic [31:0] x_image, // controller input points
	output logic run_led, // run indicator
	output logic [3:0] ch_led, // channel indicators
	input wire logic [3:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata // read data, cycle after strobe
);
	typedef struct packed {
		aicd_pkg::aicd_state_t st;
		aicd_pkg::aicd_cfg_t cfg;
		logic [1:0] boot_cnt;
		logic [7:0] jmp_s1;
		logic [7:0] jmp_s2;
		logic scan_s1;
		logic scan_s2;
		logic scan_prev;
		logic [1:0] conv_chan;
		logic seq_en;
		logic [31:0] image;
		logic [3:0] sign_bits;
		logic [3:0] broken_bits;
		logic [3:0] led_oh;
		logic [23:0] flash_cnt;
		logic flash;
		logic [31:0] rdata;
	} aicd_st_t;

	aicd_st_t s_reg;
	aicd_st_t s_next;
	aicd_pkg::aicd_sample_t q_in;
	aicd_pkg::aicd_sample_t q_out;
	logic q_in_ready;
	logic q_out_valid;
	logic q_pop;
	logic running;
	logic bipolar;
	logic neg;
	logic [15:0] fmt32;
	logic [12:0] tc13;
	logic [11:0] tc12;
	logic [12:0] uns;
	logic [27:0] bcd_prod;
	logic [15:0] bcd;

	// ------------------------------------------------------------------
	// binary to four BCD digits, value below 10000
	// ------------------------------------------------------------------
	function automatic logic [15:0] to_bcd(input logic [13:0] bin);
		logic [29:0] sh;
		sh = {16'h0000, bin};
		for (int i = 0; i < 14; i++) begin
			for (int d = 0; d < 4; d++) begin
				if (sh[14 + 4*d +: 4] > 4'h4) begin
					sh[14 + 4*d +: 4] = sh[14 + 4*d +: 4] + 4'h3;
				end
			end
			sh = {sh[28:0], 1'b0};
		end
		return sh[29:14];
	endfunction : to_bcd

	assign running = (s_reg.st == aicd_pkg::AICD_ST_RUN);
	// only enabled channels are sequenced and queued [RQ3]
	assign q_in = '{chan: s_reg.conv_chan, raw: conv_data};
	// a full queue stalls the front end instead of dropping samples
	assign conv_ready = running && s_reg.seq_en && q_in_ready;
	assign conv_req = running && s_reg.seq_en;
	assign conv_chan = s_reg.conv_chan;
	// a scan with an empty queue leaves the image as it was
	assign q_pop = running && s_reg.scan_s2 && !s_reg.scan_prev;

	aicd_fifo #(
		.WIDTH($bits(aicd_pkg::aicd_sample_t)),
		.DEPTH(`AICD_FIFO_DEPTH)
	) u_queue (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(conv_valid && conv_ready),
		.in_ready(q_in_ready),
		.in_data(q_in),
		.out_valid(q_out_valid),
		.out_ready(q_pop),
		.out_data(q_out)
	);

	// ------------------------------------------------------------------
	// data formatting of the queue head
	// ------------------------------------------------------------------
	always_comb begin
		// ranges 0 to 3 are bipolar in either mode [RQ7]
		bipolar = !s_reg.cfg.range_code[2];
		neg = q_out.raw.neg && bipolar;
		tc13 = neg ? 13'(~{1'b0, q_out.raw.mag} + 13'h0001) :
			{1'b0, q_out.raw.mag};
		tc12 = neg ? 12'(~{1'b0, q_out.raw.mag[11:1]} + 12'h001) :
			{1'b0, q_out.raw.mag[11:1]};
		if (!bipolar) begin
			uns = {1'b0, q_out.raw.mag};
		end else if (neg) begin
			uns = (`AICD_FULL_SCALE - {1'b0, q_out.raw.mag}) >> 1;
		end else begin
			uns = (`AICD_FULL_SCALE + {1'b0, q_out.raw.mag}) >> 1;
		end
		// scale 4095 to 9999 or 5000 with a 12-bit fraction [RQ9]
		bcd_prod = {2'b00, q_out.raw.mag} *
			((s_reg.cfg.range_code == `AICD_RNG_BCD10) ?
			`AICD_BCD10_K : `AICD_BCD5_K);
		bcd = to_bcd(bcd_prod[25:12]);
		// BCD ranges override the units jumpers [RQ12] [RQ9]
		if (s_reg.cfg.range_code == `AICD_RNG_BCD10 ||
				s_reg.cfg.range_code == `AICD_RNG_BCD5) begin
			fmt32 = bcd;
		end else begin
			case (s_reg.cfg.units) // [RQ10] [RQ18]
				`AICD_UNI_MAGSGN: fmt32 = {3'b000, neg, q_out.raw.mag};
				`AICD_UNI_TC13: fmt32 = {{3{tc13[12]}}, tc13};
				`AICD_UNI_TC12: fmt32 = {{4{tc12[11]}}, tc12};
				`AICD_UNI_UNS: fmt32 = {4'h0, uns[11:0]};
				default: fmt32 = 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// control and register processes
	// ------------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		// the first stage feeds only the second
		s_next.jmp_s1 = jumper_pins;
		s_next.jmp_s2 = s_reg.jmp_s1;
		s_next.scan_s1 = scan_pin;
		s_next.scan_s2 = s_reg.scan_s1;
		s_next.scan_prev = s_reg.scan_s2;
		s_next.rdata = 32'h0000_0000;

		case (s_reg.st)
			aicd_pkg::AICD_ST_BOOT: begin
				// wait for the synchroniser to fill, then latch once
				// config taken once; later jumper moves need a reset
				s_next.boot_cnt = s_reg.boot_cnt + 2'h1;
				if (s_reg.boot_cnt == `AICD_BOOT_WAIT) begin
					s_next.cfg.chan_last = {
						s_reg.jmp_s2[`AICD_JMP_CNT_B],
						s_reg.jmp_s2[`AICD_JMP_CNT_A]}; // [RQ2]
					s_next.cfg.mode32 = s_reg.jmp_s2[`AICD_JMP_MODE]; // [RQ4]
					s_next.cfg.range_code =
						s_reg.jmp_s2[`AICD_JMP_RANGE_LSB +: 3]; // [RQ6]
					s_next.cfg.units =
						s_reg.jmp_s2[`AICD_JMP_UNITS_LSB +: 2]; // [RQ1]
					s_next.cfg.invalid = !s_reg.jmp_s2[`AICD_JMP_MODE] &&
						!s_reg.jmp_s2[`AICD_JMP_RANGE_LSB + 2] &&
						!s_reg.jmp_s2[`AICD_JMP_RANGE_LSB + 1]; // [RQ19]
					// units jumpers have no effect in 16-input mode [RQ11]
					if (!s_reg.jmp_s2[`AICD_JMP_MODE]) begin
						s_next.cfg.units = `AICD_UNI_MAGSGN;
					end
					s_next.st = s_next.cfg.invalid ?
						aicd_pkg::AICD_ST_FAULT : aicd_pkg::AICD_ST_RUN;
				end
			end
			aicd_pkg::AICD_ST_RUN: begin
				// channel 1 first, wrap after the last enabled one [RQ16]
				if (conv_valid && conv_ready) begin
					s_next.conv_chan = (s_reg.conv_chan ==
						s_reg.cfg.chan_last) ? 2'h0 :
						s_reg.conv_chan + 2'h1; // [RQ2] [RQ3]
				end
				// one channel per scan edge [RQ16]
				if (q_pop && q_out_valid) begin
					s_next.led_oh = 4'h1 << q_out.chan;
					if (s_reg.cfg.mode32) begin
						s_next.sign_bits[q_out.chan] = fmt32 != 16'h0000 &&
							neg; // [RQ14]
						s_next.broken_bits[q_out.chan] = q_out.raw.open_loop &&
							s_reg.cfg.range_code == `AICD_RNG_BROKEN;
						s_next.image = {4'h0,
							s_next.broken_bits, s_next.sign_bits,
							4'h1 << q_out.chan, fmt32}; // [RQ5] [RQ17]
					end else begin
						// 16 points, plain 12-bit data only [RQ15] [RQ8]
						s_next.image = {16'h0000,
							q_out.raw.open_loop &&
							s_reg.cfg.range_code == `AICD_RNG_BROKEN,
							neg, q_out.chan,
							q_out.raw.mag}; // [RQ14] [RQ5] [RQ17]
					end
				end
			end
			aicd_pkg::AICD_ST_FAULT: begin
				// fast blink on channel 1, image held at zero [RQ13]
				// rate is a parameter so a bench can shorten the blink
				if (s_reg.flash_cnt >= 24'(FLASH_HALF_CYC - 1)) begin
					s_next.flash_cnt = 24'h00_0000;
					s_next.flash = !s_reg.flash;
				end else begin
					s_next.flash_cnt = s_reg.flash_cnt + 24'h00_0001;
				end
			end
			default: s_next.st = aicd_pkg::AICD_ST_BOOT;
		endcase

		if (reg_wr && reg_addr == `AICD_REG_CTRL) begin
			s_next.seq_en = reg_wdata[0];
		end
		if (reg_rd) begin
			case (reg_addr)
				`AICD_REG_CTRL: s_next.rdata = {31'h0000_0000, s_reg.seq_en};
				// 13 status bits packed low, the rest read zero
				`AICD_REG_STATUS: s_next.rdata = {16'h0000, 3'h0,
					q_out_valid, s_reg.st == aicd_pkg::AICD_ST_FAULT,
					s_reg.conv_chan, s_reg.cfg.units, s_reg.cfg.range_code,
					s_reg.cfg.mode32, s_reg.cfg.chan_last, s_reg.cfg.invalid};
				`AICD_REG_IMAGE: s_next.rdata = s_reg.image;
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.seq_en <= `AICD_CTRL_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign x_image = s_reg.image;
	assign run_led = running; // [RQ13]
	assign ch_led = (s_reg.st == aicd_pkg::AICD_ST_FAULT) ?
		{3'b000, s_reg.flash} : s_reg.led_oh; // [RQ13]
	assign reg_rdata = s_reg.rdata;
endmodule : aicd_decoder

// >>> tb/aicd_assertions.sv
/* port checker for the configuration decoder, bound to its top.
 * assumes jumpers only change while reset is held. */
`timescale 1ns/1ps
module aicd_assertions (
	input wire logic mclk, // clock
	input wire logic rst_n, // async reset
	input wire logic [7:0] jumper_pins, // jumper bank
	input wire logic conv_req, // sequencing on
	input wire logic [1:0] conv_chan, // channel asked
	input wire logic conv_valid, // front end offers
	input wire logic conv_ready, // sample taken
	input wire logic [31:0] x_image, // input image
	input wire logic run_led, // run indicator
	input wire logic [3:0] ch_led // channel indicators
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic bad_cfg;
	assign bad_cfg = !jumper_pins[2] && jumper_pins[5:3] < 3'h2;
	sequence s_take;
		conv_valid && conv_ready;
	endsequence
	a_ready_gated: assert property (conv_ready |-> conv_req)
		else $error("ready without sequencing");
	a_chan_wrap: assert property (s_take ##0 conv_chan == jumper_pins[1:0]
		|=> conv_chan == 2'h0) else $error("channel did not wrap");
	a_chan_step: assert property (s_take ##0 conv_chan != jumper_pins[1:0]
		|=> conv_chan == $past(conv_chan) + 2'h1) else $error("bad step");
	a_chan_hold: assert property (conv_req && !(conv_valid && conv_ready)
		|=> $stable(conv_chan)) else $error("channel moved");
	a_chan_bound: assert property (conv_req |-> conv_chan <= jumper_pins[1:0])
		else $error("disabled channel converted");
	a_fault_dark: assert property (bad_cfg |-> !run_led)
		else $error("run lit on bad jumpers");
	a_fault_blank: assert property (bad_cfg |-> x_image == '0 && !ch_led[3:1])
		else $error("fault image not blank");
	a_fault_flash: assert property (bad_cfg |-> ##[1:16] ch_led[0] != $past(ch_led[0]))
		else $error("channel 1 not flashing");
	a_image_narrow: assert property (run_led && !jumper_pins[2]
		|-> x_image[31:16] == 16'h0) else $error("16 mode upper bits set");
	a_image_wide: assert property (run_led && jumper_pins[2]
		|-> x_image[31:28] == 4'h0) else $error("32 mode top bits set");
	a_led_onehot: assert property (run_led |-> $onehot0(ch_led))
		else $error("channel leds not one-hot");
endmodule : aicd_assertions

bind aicd_decoder aicd_assertions u_chk (.mclk, .rst_n, .jumper_pins,
	.conv_req, .conv_chan, .conv_valid, .conv_ready, .x_image, .run_led,
	.ch_led);

// >>> tb/aicd_front_model.sv
/* analog front end model: offers one result per request.
 * assumes the bench sets per-channel results and the stall input. */
`timescale 1ns/1ps
module aicd_front_model (
	input wire logic mclk, // clock
	input wire logic rst_n, // async reset
	input wire logic conv_req, // convert request
	input wire logic [1:0] conv_chan, // channel to convert
	input wire logic conv_ready, // result taken
	input wire logic stall, // slow converter
	input wire aicd_pkg::aicd_raw_t ch_val [4], // result per channel
	output logic conv_valid, // result offered
	output aicd_pkg::aicd_raw_t conv_data // result
);
	// offer held until taken; idle data inverted so stale values never match
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			conv_valid <= 1'b0;
		end else if (!conv_valid || conv_ready) begin
			conv_valid <= conv_req && !stall;
		end
	end
	assign conv_data = conv_valid ? ch_val[conv_chan] : ~ch_val[conv_chan];
endmodule : aicd_front_model

// >>> tb/tb_top.sv
/* self-checking bench of the configuration decoder.
 * assumes the checker and front end model are compiled first. */
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
	fail_count++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_top;
	logic mclk = 0, rst_n = 0, scan_pin = 0, reg_wr = 0, reg_rd = 0, stall = 0;
	logic conv_req, conv_ready, conv_valid, run_led;
	logic [7:0] jp = 8'hFF;
	logic [3:0] reg_addr = 4'h0, ch_led;
	logic [31:0] reg_wdata = '0, reg_rdata, x_image, rd;
	logic [1:0] conv_chan;
	aicd_pkg::aicd_raw_t conv_data, ch_val [4];
	int fail_count = 0, num_checks = 0;
	logic [7:0] tj [10] = '{8'h14, 8'h54, 8'h94, 8'hD4, 8'hC4, 8'h0C, 8'hF4,
		8'hF0, 8'h00, 8'h08};
	logic [13:0] tv [10] = '{14'h1123, 14'h1123, 14'h1123, 14'h1123, 14'h1FFF,
		14'h0FFF, 14'h2ABC, 14'h2ABC, 14'h0123, 14'h0123};
	logic [31:0] te [10] = '{32'h0011_1123, 32'h0011_FEDD, 32'h0011_FF6F,
		32'h0011_076E, 32'h0011_9999, 32'h0001_5000, 32'h0101_0ABC,
		32'h0000_8ABC, '0, '0};
	initial forever #2.5 mclk = ~mclk;
	aicd_decoder #(.FLASH_HALF_CYC(4)) dut (.mclk, .rst_n, .jumper_pins(jp),
		.scan_pin, .conv_req, .conv_chan, .conv_valid, .conv_ready, .conv_data,
		.x_image, .run_led, .ch_led, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	aicd_front_model fe (.mclk, .rst_n, .conv_req, .conv_chan, .conv_ready,
		.stall, .ch_val, .conv_valid, .conv_data);
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic boot(input logic [7:0] j);
		rst_n <= 1'b0;
		jp <= j;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (14) @(posedge mclk);
	endtask : boot
	task automatic rd32(input logic [3:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
		@(posedge mclk);
	endtask : rd32
	task automatic wr32(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wr32
	// pulse kept 4 cycles each way, past the synchroniser
	task automatic scan(input logic [31:0] exp);
		scan_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		scan_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		`CHK(x_image, exp)
	endtask : scan
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	initial begin
		ch_val <= '{14'h0123, 14'h0456, 14'h0789, 14'h0ABC};
		boot(8'hFF);
		rd32(4'h4, rd);
		`CHK(rd & 32'h0000_09FF, 32'h0000_01FE)
		rd32(4'h0, rd);
		`CHK(rd, 32'h0000_0001)
		for (int i = 0; i < 5; i++) begin
			scan({12'h000, 4'h1 << (i % 4), 4'h0, ch_val[i % 4].mag});
			`CHK(ch_led, 4'h1 << (i % 4))
		end
		stall <= 1'b1;
		wr32(4'h0, '0);
		`CHK(conv_req, 1'b0)
		rd32(4'hC, rd);
		`CHK(rd, '0)
		stall <= 1'b0;
		$display("test sequencing done");
		ch_val <= '{14'h1123, 14'h0456, 14'h0789, 14'h0ABC};
		boot(8'hD1);
		rd32(4'h4, rd);
		`CHK(rd & 32'h0000_09FF, 32'h0000_0022)
		scan(32'h0000_4123);
		scan(32'h0000_1456);
		scan(32'h0000_4123);
		rd32(4'h8, rd);
		`CHK(rd, 32'h0000_4123)
		$display("test narrow mode done");
		for (int k = 0; k < 10; k++) begin
			ch_val[0] <= tv[k];
			boot(tj[k]);
			`CHK(run_led, k < 8)
			rd32(4'h4, rd);
			`CHK(rd[0], k > 7)
			scan(te[k]);
			$display("test jumper case %0d done", k);
		end
		final_report();
	end
	// whole run needs under 2000 cycles; allow five times that
	initial begin
		#50000;
		fail_count++;
		final_report();
	end
endmodule : tb_top
